// ### hw/sso_sequencer.sv
// safe stop one sequencer with APB register slave
// Summary of operation
// - brake control fault forces torque off, raises both fault messages, closes brake
// - basic variant ramps a running motor down on the quick-stop ramp
// - basic variant enters torque off once the delay time has elapsed
// - basic variant supervises no speed and flags no limit violation
// - extended variants go straight to torque off if motor already off
// - brake-ramp variant checks that load speed keeps falling while ramping
// - brake-ramp variant enters torque off at the standstill threshold
// - acceleration variant supervises deceleration during the quick-stop ramp
// - acceleration variant enters torque off at standstill or delay, whichever first
// - a rising main on command is refused while the stop is active
// - without an active stop, switching on needs no coast or quick stop command; switching off is unrestricted
// - extended variants flag speed beyond the monitoring limit as a violation
// - channel discrepancy on the fail-safe input is latched as input error
// - switch-off during the stop reacts to coast stop only; main off and quick stop leave the ramp running
// - basic variant reports torque-off and stop-active flags for outputs
// - extended variants report their own torque-off and stop-active flags
// - deselect taken from telegram, basic and extended apart, or from the fail-safe input shared by both
//
// Implementation choices: the APB interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none
module sso_sequencer #(
    parameter int unsigned TICK_CYCLES = sso_pkg::TICK_CYCLES,
    parameter int unsigned DISC_TOL_CYCLES = sso_pkg::DISC_TOL_CYCLES
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic failsafeInputA,
    input wire logic failsafeInputB,
    input wire logic basicStopDeselect,
    input wire logic extStopDeselect,
    input wire logic mainOnCommand,
    input wire logic coastStopCommand,
    input wire logic quickStopCommand,
    input wire logic [15:0] motorSpeed,
    input wire logic brakeFaultPin,
    output logic motorOn,
    output logic quickStopRamp,
    output logic torqueOff,
    output logic brakeClose,
    output logic brakeFaultMsgA,
    output logic brakeFaultMsgB,
    output sso_pkg::sso_flags_type flags,
    output sso_pkg::sso_faults_type faults
);
    // speed above reference plus tolerance
    function automatic logic overLimit(input logic [15:0] spd, input logic [15:0] ref16,
                                       input logic [15:0] tol);
        overLimit = {1'b0, spd} > ({1'b0, ref16} + {1'b0, tol});
    endfunction

    sso_pkg::sso_variant_type variant;
    logic [15:0] delayMs;
    logic [15:0] stillSpeed;
    logic [15:0] limitTol;
    sso_pkg::sso_variant_type next_variant;
    logic [15:0] next_delayMs;
    logic [15:0] next_stillSpeed;
    logic [15:0] next_limitTol;
    logic [31:0] next_prdata;
    logic next_pslverr;
    logic ackPulse;
    logic setupPhase;
    logic writeTaken;

    sso_pkg::sso_state_type state;
    sso_pkg::sso_state_type next_state;
    sso_pkg::sso_faults_type next_faults;
    sso_pkg::sso_flags_type next_flags;
    logic next_motorOn;
    logic mainOnPrev;
    logic coastOff;
    logic next_coastOff;
    logic ranAtStart;
    logic next_ranAtStart;
    logic [15:0] refSpeed;
    logic [15:0] next_refSpeed;
    logic [2:0] brakeSync;
    logic brakeLevel;
    logic next_brakeLevel;
    logic fdiDeselect;
    logic fdiDiscrepant;
    logic msTick;
    logic delayExpired;
    logic stopRequest;
    logic isBasic;
    logic monitorOn;
    logic violation;
    logic atStill;

    sso_fdi_filter #(.TOL_CYCLES(DISC_TOL_CYCLES)) uFilter (
        .clk(clk),
        .rst_n(rst_n),
        .chanA(failsafeInputA),
        .chanB(failsafeInputB),
        .deselect(fdiDeselect),
        .discrepant(fdiDiscrepant)
    );

    sso_delay_timer #(.TICK_CYCLES(TICK_CYCLES)) uTimer (
        .clk(clk),
        .rst_n(rst_n),
        .run(state == sso_pkg::SSO_RAMP),
        .delayMs(delayMs),
        .tick(msTick),
        .expired(delayExpired)
    );

    // zero wait states: read data is captured in the setup cycle
    assign pready = 1'b1;
    assign setupPhase = psel & ~penable;
    assign writeTaken = psel & penable & pwrite;
    assign ackPulse = writeTaken & (paddr == sso_pkg::ADDR_CTRL) & pwdata[sso_pkg::CTRL_ACK_BIT];

    always_comb begin
        next_variant = variant;
        next_delayMs = delayMs;
        next_stillSpeed = stillSpeed;
        next_limitTol = limitTol;
        next_prdata = prdata;
        next_pslverr = 1'b0;
        if (setupPhase) begin
            next_prdata = 32'h0;
            unique case (paddr)
                sso_pkg::ADDR_CTRL: next_prdata = {30'h0, variant};
                sso_pkg::ADDR_DELAY: next_prdata = {16'h0, delayMs};
                sso_pkg::ADDR_STILL: next_prdata = {16'h0, stillSpeed};
                sso_pkg::ADDR_LIMTOL: next_prdata = {16'h0, limitTol};
                sso_pkg::ADDR_STATUS: next_prdata = {21'h0, state, faults, flags};
                default: next_pslverr = 1'b1;
            endcase
            if (pwrite && paddr == sso_pkg::ADDR_STATUS) begin
                next_pslverr = 1'b1;
            end
        end else begin
            next_pslverr = pslverr;
        end
        if (writeTaken && state == sso_pkg::SSO_IDLE) begin
            unique case (paddr)
                sso_pkg::ADDR_CTRL: begin
                    if (pwdata[1:0] != 2'h3) begin
                        next_variant = sso_pkg::sso_variant_type'(pwdata[1:0]);
                    end
                end
                sso_pkg::ADDR_DELAY: next_delayMs = pwdata[15:0];
                sso_pkg::ADDR_STILL: next_stillSpeed = pwdata[15:0];
                sso_pkg::ADDR_LIMTOL: next_limitTol = pwdata[15:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            variant <= sso_pkg::sso_variant_type'(sso_pkg::VAR_RST);
            delayMs <= sso_pkg::DELAY_RST;
            stillSpeed <= sso_pkg::STILL_RST;
            limitTol <= sso_pkg::LIMTOL_RST;
            prdata <= 32'h0;
            pslverr <= 1'b0;
        end else begin
            variant <= next_variant;
            delayMs <= next_delayMs;
            stillSpeed <= next_stillSpeed;
            limitTol <= next_limitTol;
            prdata <= next_prdata;
            pslverr <= next_pslverr;
        end
    end

    assign isBasic = (variant == sso_pkg::SSO_VAR_BASIC);
    assign stopRequest = isBasic ? (~basicStopDeselect | ~fdiDeselect | faults.inputError)
                                 : (~extStopDeselect | ~fdiDeselect | faults.inputError);
    // monitoring only for extended variants on a running motor
    assign monitorOn = (state == sso_pkg::SSO_RAMP) & ~isBasic & ranAtStart;
    assign atStill = motorSpeed <= stillSpeed;

    always_comb begin
        next_brakeLevel = (brakeSync[1] == brakeSync[2]) ? brakeSync[2] : brakeLevel;
        next_refSpeed = refSpeed;
        violation = 1'b0;
        if (state == sso_pkg::SSO_IDLE) begin
            next_refSpeed = motorSpeed;
        end else if (monitorOn) begin
            if (variant == sso_pkg::SSO_VAR_BRAKE_RAMP) begin
                // speed must not rise between ticks
                if (msTick) begin
                    violation = overLimit(motorSpeed, refSpeed, limitTol);
                    next_refSpeed = motorSpeed;
                end
            end else begin
                // lowest speed seen is the reference
                violation = overLimit(motorSpeed, refSpeed, limitTol);
                if (motorSpeed < refSpeed) begin
                    next_refSpeed = motorSpeed;
                end
            end
        end
        // sticky: a new event wins over acknowledge
        next_faults = faults;
        if (ackPulse) begin
            next_faults = '0;
        end
        if (brakeLevel) begin
            next_faults.brakeFault = 1'b1;
        end
        if (fdiDiscrepant) begin
            next_faults.inputError = 1'b1;
        end
        if (violation) begin
            next_faults.limitViolation = 1'b1;
        end
    end

    always_comb begin
        next_state = state;
        next_coastOff = coastOff;
        next_ranAtStart = ranAtStart;
        next_motorOn = motorOn;
        unique case (state)
            sso_pkg::SSO_IDLE: begin
                next_coastOff = 1'b0;
                // switch-on only while no stop runs
                if (mainOnCommand && !mainOnPrev && !coastStopCommand && !quickStopCommand) begin
                    next_motorOn = 1'b1;
                end
                if (!mainOnCommand || coastStopCommand || quickStopCommand) begin
                    next_motorOn = 1'b0;
                end
                if (faults.brakeFault || brakeLevel) begin
                    next_state = sso_pkg::SSO_TORQUE_OFF;
                end else if (stopRequest) begin
                    next_ranAtStart = motorOn;
                    next_state = (!isBasic && !motorOn) ? sso_pkg::SSO_TORQUE_OFF
                                                        : sso_pkg::SSO_RAMP;
                end
            end
            sso_pkg::SSO_RAMP: begin
                // main off and quick stop leave the ramp running
                if (coastStopCommand) begin
                    next_motorOn = 1'b0;
                    next_coastOff = 1'b1;
                end
                if (brakeLevel || violation) begin
                    next_state = sso_pkg::SSO_TORQUE_OFF;
                end else if (!stopRequest) begin
                    next_state = sso_pkg::SSO_IDLE;
                end else if (isBasic) begin
                    if (delayExpired) begin
                        next_state = sso_pkg::SSO_TORQUE_OFF;
                    end
                end else if (coastStopCommand) begin
                    next_state = sso_pkg::SSO_TORQUE_OFF;
                end else if (variant == sso_pkg::SSO_VAR_BRAKE_RAMP) begin
                    if (atStill) begin
                        next_state = sso_pkg::SSO_TORQUE_OFF;
                    end
                end else if (atStill || delayExpired) begin
                    next_state = sso_pkg::SSO_TORQUE_OFF;
                end
            end
            sso_pkg::SSO_TORQUE_OFF: begin
                next_motorOn = 1'b0;
                next_coastOff = 1'b0;
                if (!stopRequest && !faults.brakeFault && !brakeLevel) begin
                    next_state = sso_pkg::SSO_IDLE;
                end
            end
            default: next_state = sso_pkg::SSO_TORQUE_OFF;
        endcase
        next_flags.basicTorqueOffActiveFlag = isBasic & (next_state == sso_pkg::SSO_TORQUE_OFF);
        next_flags.basicStopActiveFlag = isBasic & (next_state != sso_pkg::SSO_IDLE);
        next_flags.extTorqueOffActiveFlag = ~isBasic & (next_state == sso_pkg::SSO_TORQUE_OFF);
        next_flags.extStopActiveFlag = ~isBasic & (next_state != sso_pkg::SSO_IDLE);
        next_flags.rampMonitorActiveFlag = ~isBasic & next_ranAtStart
                                           & (next_state == sso_pkg::SSO_RAMP);
        next_flags.readyToSwitchOnFlag = (next_state == sso_pkg::SSO_IDLE) & ~next_motorOn
                                         & ~next_faults.brakeFault & ~stopRequest;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= sso_pkg::SSO_IDLE;
            faults <= '0;
            flags <= '0;
            motorOn <= 1'b0;
            mainOnPrev <= 1'b1;
            coastOff <= 1'b0;
            ranAtStart <= 1'b0;
            refSpeed <= 16'h0;
            brakeSync <= 3'h0;
            brakeLevel <= 1'b0;
            quickStopRamp <= 1'b0;
            torqueOff <= 1'b0;
            brakeClose <= 1'b1;
            brakeFaultMsgA <= 1'b0;
            brakeFaultMsgB <= 1'b0;
        end else begin
            state <= next_state;
            faults <= next_faults;
            flags <= next_flags;
            motorOn <= next_motorOn & (next_state != sso_pkg::SSO_TORQUE_OFF);
            mainOnPrev <= mainOnCommand;
            coastOff <= next_coastOff;
            ranAtStart <= next_ranAtStart;
            refSpeed <= next_refSpeed;
            brakeSync <= {brakeSync[1:0], brakeFaultPin};
            brakeLevel <= next_brakeLevel;
            // quick-stop ramp on a running motor
            quickStopRamp <= (next_state == sso_pkg::SSO_RAMP) & next_motorOn;
            // coast in basic variant removes torque before delay ends
            torqueOff <= (next_state == sso_pkg::SSO_TORQUE_OFF) | next_coastOff;
            // brake closes on fault, torque off, standstill in ramp or motor off
            brakeClose <= (next_state == sso_pkg::SSO_TORQUE_OFF) | next_faults.brakeFault
                          | ((next_state == sso_pkg::SSO_RAMP) & atStill) | ~next_motorOn;
            brakeFaultMsgA <= next_faults.brakeFault;
            brakeFaultMsgB <= next_faults.brakeFault;
        end
    end
endmodule
`default_nettype wire

// ### hw/sso_pkg.sv
// shared constants and types of the safe stop one sequencer
package sso_pkg;
    localparam int unsigned CLK_HZ = 40_000_000;
    localparam int unsigned TICK_US = 1000;
    localparam int unsigned TICK_CYCLES = CLK_HZ / 1_000_000 * TICK_US;
    localparam int unsigned DISC_TOL_US = 2000;
    localparam int unsigned DISC_TOL_CYCLES = CLK_HZ / 1_000_000 * DISC_TOL_US;
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_DELAY = 8'h04;
    localparam logic [7:0] ADDR_STILL = 8'h08;
    localparam logic [7:0] ADDR_LIMTOL = 8'h0c;
    localparam logic [7:0] ADDR_STATUS = 8'h10;
    localparam int unsigned CTRL_VAR_LSB = 0;
    localparam int unsigned CTRL_ACK_BIT = 2;
    localparam logic [1:0] VAR_RST = 2'h0;
    localparam logic [15:0] DELAY_RST = 16'h0064;
    localparam logic [15:0] STILL_RST = 16'h000a;
    localparam logic [15:0] LIMTOL_RST = 16'h0020;
    typedef enum logic [1:0] {
        SSO_VAR_BASIC,
        SSO_VAR_BRAKE_RAMP,
        SSO_VAR_ACCEL
    } sso_variant_type;
    typedef enum logic [1:0] {
        SSO_IDLE,
        SSO_RAMP,
        SSO_TORQUE_OFF
    } sso_state_type;
    typedef struct packed {
        logic readyToSwitchOnFlag;
        logic rampMonitorActiveFlag;
        logic extStopActiveFlag;
        logic extTorqueOffActiveFlag;
        logic basicStopActiveFlag;
        logic basicTorqueOffActiveFlag;
    } sso_flags_type;
    typedef struct packed {
        logic limitViolation;
        logic inputError;
        logic brakeFault;
    } sso_faults_type;
endpackage

// ### hw/sso_fdi_filter.sv
// two-channel fail-safe input: synchronisers and discrepancy timer
`timescale 1ns/1ps
`default_nettype none
module sso_fdi_filter #(
    parameter int unsigned TOL_CYCLES = sso_pkg::DISC_TOL_CYCLES
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic chanA,
    input wire logic chanB,
    output logic deselect,
    output logic discrepant
);
    logic [2:0] syncA;
    logic [2:0] syncB;
    logic agreedA;
    logic agreedB;
    logic [31:0] discCount;
    logic next_agreedA;
    logic next_agreedB;
    logic [31:0] next_discCount;
    logic next_discrepant;
    logic next_deselect;

    always_comb begin
        // a level counts only once the last two stages agree
        next_agreedA = (syncA[1] == syncA[2]) ? syncA[2] : agreedA;
        next_agreedB = (syncB[1] == syncB[2]) ? syncB[2] : agreedB;
        next_discCount = 32'h0;
        next_discrepant = 1'b0;
        if (next_agreedA != next_agreedB) begin
            next_discCount = discCount;
            if (discCount >= TOL_CYCLES) begin
                next_discrepant = 1'b1;
            end else begin
                next_discCount = discCount + 32'h1;
            end
        end
        // deselect only when both channels say so; a lone channel selects
        next_deselect = next_agreedA & next_agreedB;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            syncA <= 3'h0;
            syncB <= 3'h0;
            agreedA <= 1'b0;
            agreedB <= 1'b0;
            discCount <= 32'h0;
            discrepant <= 1'b0;
            deselect <= 1'b0;
        end else begin
            syncA <= {syncA[1:0], chanA};
            syncB <= {syncB[1:0], chanB};
            agreedA <= next_agreedA;
            agreedB <= next_agreedB;
            discCount <= next_discCount;
            discrepant <= next_discrepant;
            deselect <= next_deselect;
        end
    end
endmodule
`default_nettype wire

// ### hw/sso_delay_timer.sv
// millisecond tick divider and stop delay counter
`timescale 1ns/1ps
`default_nettype none
module sso_delay_timer #(
    parameter int unsigned TICK_CYCLES = sso_pkg::TICK_CYCLES
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic run,
    input wire logic [15:0] delayMs,
    output logic tick,
    output logic expired
);
    logic [31:0] divCount;
    logic [15:0] msCount;
    logic [31:0] next_divCount;
    logic [15:0] next_msCount;
    logic next_tick;
    logic next_expired;

    always_comb begin
        next_tick = (divCount == TICK_CYCLES - 1);
        next_divCount = next_tick ? 32'h0 : divCount + 32'h1;
        next_msCount = msCount;
        next_expired = expired;
        if (!run) begin
            next_msCount = 16'h0;
            next_expired = 1'b0;
        end else if (msCount >= delayMs) begin
            next_expired = 1'b1;
        end else if (tick) begin
            next_msCount = msCount + 16'h1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            divCount <= 32'h0;
            msCount <= 16'h0;
            tick <= 1'b0;
            expired <= 1'b0;
        end else begin
            divCount <= next_divCount;
            msCount <= next_msCount;
            tick <= next_tick;
            expired <= next_expired;
        end
    end
endmodule
`default_nettype wire

// ### verif/sso_fdi_ctrl.sv
// controller model driving both fail-safe input channels
`timescale 1ns/1ps
`default_nettype none
module sso_fdi_ctrl (
    input wire logic clk,
    input wire logic selStop,
    input wire logic splitB,
    output var logic chanA = 1'b1,
    output var logic chanB = 1'b1
);
    // both channels low select the stop
    always @(posedge clk) begin
        chanA <= !selStop;
        chanB <= !selStop ^ splitB;
    end
endmodule
`default_nettype wire

// ### verif/sso_checker.sv
// port assertions of the safe stop one sequencer
`timescale 1ns/1ps
`default_nettype none
module sso_checker (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic mainOnCommand,
    input wire logic motorOn,
    input wire logic quickStopRamp,
    input wire logic torqueOff,
    input wire logic brakeClose,
    input wire logic brakeFaultMsgA,
    input wire logic brakeFaultMsgB,
    input wire sso_pkg::sso_flags_type flags,
    input wire sso_pkg::sso_faults_type faults
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    wire logic stopAct = flags.basicStopActiveFlag | flags.extStopActiveFlag;
    sequence s_onRise;
        $rose(mainOnCommand);
    endsequence
    sequence s_offStop;
        stopAct && !motorOn;
    endsequence
    property p_onRefused;
        s_offStop ##0 s_onRise |=> !motorOn;
    endproperty
    a_onRefused: assert property (p_onRefused) else $error("main on taken in stop");
    property p_brake;
        $rose(faults.brakeFault) |-> ##[0:2] (torqueOff && brakeClose && brakeFaultMsgA);
    endproperty
    a_brake: assert property (p_brake) else $error("brake fault not handled");
    property p_msgPair;
        brakeFaultMsgA == brakeFaultMsgB;
    endproperty
    a_msgPair: assert property (p_msgPair) else $error("fault messages differ");
    property p_ramp;
        flags.basicStopActiveFlag && motorOn |-> quickStopRamp;
    endproperty
    a_ramp: assert property (p_ramp) else $error("no ramp while stopping");
    property p_basicOff;
        flags.basicTorqueOffActiveFlag |-> torqueOff;
    endproperty
    a_basicOff: assert property (p_basicOff) else $error("basic flag without torque off");
    property p_noViol;
        flags.basicStopActiveFlag |=> !$rose(faults.limitViolation);
    endproperty
    a_noViol: assert property (p_noViol) else $error("violation in basic stop");
    property p_extOff;
        flags.extTorqueOffActiveFlag |-> torqueOff && !motorOn;
    endproperty
    a_extOff: assert property (p_extOff) else $error("extended flag without torque off");
    property p_ready;
        flags.readyToSwitchOnFlag |-> !motorOn && !stopAct;
    endproperty
    a_ready: assert property (p_ready) else $error("ready while running or stopping");
    property p_monitor;
        flags.rampMonitorActiveFlag |-> flags.extStopActiveFlag && !torqueOff;
    endproperty
    a_monitor: assert property (p_monitor) else $error("monitor outside extended ramp");
endmodule
bind sso_sequencer sso_checker chk_u (.clk(clk), .rst_n(rst_n), .mainOnCommand(mainOnCommand),
    .motorOn(motorOn), .quickStopRamp(quickStopRamp), .torqueOff(torqueOff),
    .brakeClose(brakeClose), .brakeFaultMsgA(brakeFaultMsgA), .brakeFaultMsgB(brakeFaultMsgB),
    .flags(flags), .faults(faults));
`default_nettype wire

// ### verif/tb.sv
// self-checking bench of the safe stop one sequencer
`timescale 1ns/1ps
`default_nettype none
module tb;
    localparam int TK = 10;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, fa, fb, er;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, selStop = 1'b0, splitB = 1'b0, bDes = 1'b1, eDes = 1'b1;
    logic mainOn = 1'b0, coast = 1'b0, qStop = 1'b0, brk = 1'b0;
    logic [15:0] speed = 16'h0;
    logic motorOn, qRamp, torqueOff, brakeClose, msgA, msgB;
    sso_pkg::sso_flags_type flags;
    sso_pkg::sso_faults_type faults;
    int miscompares = 0, cmp_count = 0, seed = 32'h2dcd, n;
    sso_fdi_ctrl ctl_u (.clk(clk), .selStop(selStop), .splitB(splitB), .chanA(fa), .chanB(fb));
    sso_sequencer #(.TICK_CYCLES(TK), .DISC_TOL_CYCLES(8)) dut_u (.clk(clk), .rst_n(rst_n),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .failsafeInputA(fa),
        .failsafeInputB(fb), .basicStopDeselect(bDes), .extStopDeselect(eDes),
        .mainOnCommand(mainOn), .coastStopCommand(coast), .quickStopCommand(qStop),
        .motorSpeed(speed), .brakeFaultPin(brk), .motorOn(motorOn), .quickStopRamp(qRamp),
        .torqueOff(torqueOff), .brakeClose(brakeClose), .brakeFaultMsgA(msgA),
        .brakeFaultMsgB(msgB), .flags(flags), .faults(faults));
    initial begin
        forever #12.5 clk = ~clk;
    end
    function automatic logic inWin(int c, int ms);
        return c >= (ms - 1) * TK && c <= ms * TK + 6;
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic chkb(input logic got, input logic exp);
        chk(32'(got), 32'(exp));
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input logic experr);
        apb(1'b0, a, 32'h0);
        chk(rd, exp);
        chkb(er, experr);
    endtask
    // waits for torque off (0) or ready to switch on (1)
    task automatic wt(input logic rdy);
        n = 0;
        while ((rdy ? flags.readyToSwitchOnFlag : torqueOff) !== 1'b1 && n < 2000) begin
            @(posedge clk);
            n++;
        end
        if (n >= 2000) miscompares++;
    endtask
    task automatic results();
        if (miscompares == 0 && cmp_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    initial begin
        #(25 * 20000);
        miscompares++;
        results();
    end
    initial begin
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        repeat (12) @(posedge clk);
        rchk(sso_pkg::ADDR_CTRL, 32'h0, 1'b0);
        rchk(sso_pkg::ADDR_DELAY, 32'(sso_pkg::DELAY_RST), 1'b0);
        rchk(sso_pkg::ADDR_STILL, 32'(sso_pkg::STILL_RST), 1'b0);
        rchk(8'h14, 32'h0, 1'b1);
        rchk(sso_pkg::ADDR_STATUS, 32'h20, 1'b0);
        apb(1'b1, sso_pkg::ADDR_STATUS, 32'h0);
        chkb(er, 1'b1);
        apb(1'b1, sso_pkg::ADDR_DELAY, 32'h3);
        apb(1'b1, sso_pkg::ADDR_STILL, 32'h5);
        speed <= 16'h0100;
        mainOn <= 1'b1;
        repeat (3) @(posedge clk);
        chkb(motorOn, 1'b1);
        bDes <= 1'b0;
        repeat (2) @(posedge clk);
        chk(32'({qRamp, flags.basicStopActiveFlag}), 32'h3);
        qStop <= 1'b1;
        wt(1'b0);
        chkb(inWin(n + 2, 3), 1'b1);
        chk(32'({flags.basicTorqueOffActiveFlag, motorOn, faults}), 32'h10);
        mainOn <= 1'b0;
        @(posedge clk);
        mainOn <= 1'b1;
        repeat (3) @(posedge clk);
        chkb(motorOn, 1'b0);
        apb(1'b1, sso_pkg::ADDR_DELAY, 32'h9);
        rchk(sso_pkg::ADDR_DELAY, 32'h3, 1'b0);
        // restart order: deselect, ready, then main on
        bDes <= 1'b1;
        qStop <= 1'b0;
        mainOn <= 1'b0;
        wt(1'b1);
        mainOn <= 1'b1;
        repeat (3) @(posedge clk);
        chkb(motorOn, 1'b1);
        bDes <= 1'b0;
        repeat (2) @(posedge clk);
        coast <= 1'b1;
        repeat (2) @(posedge clk);
        chk(32'({torqueOff, flags.basicTorqueOffActiveFlag, flags.basicStopActiveFlag, motorOn}),
            32'ha);
        bDes <= 1'b1;
        coast <= 1'b0;
        mainOn <= 1'b0;
        wt(1'b1);
        mainOn <= 1'b1;
        repeat (3) @(posedge clk);
        for (int k = 1; k < 4; k++) begin
            apb(1'b1, sso_pkg::ADDR_CTRL, (k > 2) ? 32'h2 : 32'(k));
            speed <= 16'h0040 + 16'($random(seed) & 255);
            eDes <= 1'b0;
            repeat (4) @(posedge clk);
            chk(32'({flags.rampMonitorActiveFlag, flags.extStopActiveFlag}), 32'h3);
            if (k < 3)
                speed <= 16'h0005;
            wt(1'b0);
            chkb((k < 3) ? n < 4 : inWin(n + 4, 3), 1'b1);
            chk(32'({flags.extTorqueOffActiveFlag, motorOn, faults}), 32'h10);
            eDes <= 1'b1;
            mainOn <= 1'b0;
            wt(1'b1);
            mainOn <= 1'b1;
            repeat (3) @(posedge clk);
        end
        speed <= 16'h0100;
        eDes <= 1'b0;
        repeat (3) @(posedge clk);
        speed <= 16'h0121;
        repeat (4) @(posedge clk);
        chk(32'({faults.limitViolation, torqueOff}), 32'h3);
        eDes <= 1'b1;
        mainOn <= 1'b0;
        repeat (3) @(posedge clk);
        apb(1'b1, sso_pkg::ADDR_CTRL, 32'h5);
        chkb(motorOn, 1'b0);
        eDes <= 1'b0;
        repeat (3) @(posedge clk);
        chkb(torqueOff, 1'b1);
        eDes <= 1'b1;
        apb(1'b1, sso_pkg::ADDR_CTRL, 32'h4);
        selStop <= 1'b1;
        repeat (8) @(posedge clk);
        chkb(flags.basicStopActiveFlag, 1'b1);
        selStop <= 1'b0;
        splitB <= 1'b1;
        repeat (20) @(posedge clk);
        chk(32'({faults.inputError, flags.basicStopActiveFlag}), 32'h3);
        splitB <= 1'b0;
        brk <= 1'b1;
        repeat (6) @(posedge clk);
        chk(32'({msgA, msgB, torqueOff, brakeClose, faults.brakeFault}), 32'h1f);
        brk <= 1'b0;
        repeat (6) @(posedge clk);
        apb(1'b1, sso_pkg::ADDR_CTRL, 32'h4);
        repeat (4) @(posedge clk);
        chk(32'(faults), 32'h0);
        results();
    end
endmodule
`default_nettype wire
